// ==== rmis_defs.vh ====
// Constants for the remappable input select block.
// Assumes one clock, synchronous active-low reset, word-only AHB-Lite access.
`ifndef RMIS_DEFS_VH
`define RMIS_DEFS_VH

// ----------------------------------------
// Selector geometry
// ----------------------------------------
`define RMIS_SEL_W 8
`define RMIS_SEL_GND 8'h00
`define RMIS_PIN_MAX 8'hb5
`define RMIS_PIN_W 182
`define RMIS_REG_NUM 8
`define RMIS_SLOT_NUM 16
// One bit per byte slot: slot = 2*register index + upper byte
`define RMIS_SLOT_IMPL 16'hff5e
`define RMIS_REG_W 16
`define RMIS_RESET_SEL 8'h00

// ----------------------------------------
// Slot numbers of each peripheral input
// ----------------------------------------
`define RMIS_SLOT_T1CLK 1
`define RMIS_SLOT_T2CLK 2
`define RMIS_SLOT_T3CLK 3
`define RMIS_SLOT_CAP1 4
`define RMIS_SLOT_CFLTA 6
`define RMIS_SLOT_FLT1 8
`define RMIS_SLOT_FLT2 9
`define RMIS_SLOT_FLT3 10
`define RMIS_SLOT_FLT4 11
`define RMIS_SLOT_URX 12
`define RMIS_SLOT_UCTS 13
`define RMIS_SLOT_SDI 14
`define RMIS_SLOT_SCK 15

// ----------------------------------------
// Bus map
// ----------------------------------------
`define RMIS_IDX_LSB 2
`define RMIS_IDX_MSB 4
`define RMIS_ADDR_TOP_LSB 5
`define RMIS_HTRANS_NONSEQ_BIT 1
`define RMIS_HRESP_OKAY 1'h0
`define RMIS_ZERO_WORD 32'h00000000
`define RMIS_ZERO_HALF 16'h0000
`define RMIS_HI_MSB 15
`define RMIS_HI_LSB 8
`define RMIS_LO_MSB 7
`define RMIS_LO_LSB 0

// ----------------------------------------
// Word index of each register
// ----------------------------------------
`define RMIS_IDX_T1CLK 3'h0
`define RMIS_IDX_T3T2CLK 3'h1
`define RMIS_IDX_CAP1 3'h2
`define RMIS_IDX_CFLTA 3'h3
`define RMIS_IDX_FLT21 3'h4
`define RMIS_IDX_FLT43 3'h5
`define RMIS_IDX_UART 3'h6
`define RMIS_IDX_SPI 3'h7

`endif

// ==== rmis_pin_mux.v ====
// One selector-driven input route with a registered output.
// Assumes the pin vector is synchronous to the clock.
module rmis_pin_mux (
    // Clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // Selector and pins
    input wire [7:0] sel_i,
    input wire [181:0] pins_i,
    // Routed level
    output reg route_o
);
`include "rmis_defs.vh"

    reg next_route;

    always @* begin
        // Guard first so an out-of-range index is never used
        if (sel_i == `RMIS_SEL_GND) begin
            next_route = 1'b0;
        end else if (sel_i > `RMIS_PIN_MAX) begin
            next_route = 1'b0;
        end else begin
            next_route = pins_i[sel_i];
        end
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            route_o <= 1'b0;
        end else begin
            route_o <= next_route;
        end
    end
endmodule

// ==== rmis_top.v ====
// Remappable input select: AHB-Lite register file plus input routing.
// Assumes a single AHB-Lite master, word transfers, zero-wait slave.
module rmis_top (
    // Clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // AHB-Lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg [31:0] hrdata_o,
    // Remappable pins, index 0 unused
    input wire [181:0] remappable_pin_i,
    // Routed peripheral inputs
    output wire timer1_clock_o,
    output wire timer2_clock_o,
    output wire timer3_clock_o,
    output wire capture1_o,
    output wire compare_fault_a_o,
    output wire pwm_fault1_o,
    output wire pwm_fault2_o,
    output wire pwm_fault3_o,
    output wire pwm_fault4_o,
    output wire uart_rx_o,
    output wire uart_cts_o,
    output wire spi_data_in_o,
    output wire spi_clock_in_o
);
`include "rmis_defs.vh"

    // ----------------------------------------
    // Bus phase tracking
    // ----------------------------------------
    reg wr_pend;
    reg [2:0] wr_idx;
    wire addr_take;
    wire addr_hit;
    wire [2:0] addr_idx;
    wire [`RMIS_SEL_W-1:0] wr_hi;
    wire [`RMIS_SEL_W-1:0] wr_lo;
    wire wr_timer1;
    wire wr_timer3_timer2;
    wire wr_capture1;
    wire wr_compare_fault;
    wire wr_pwm_fault21;
    wire wr_pwm_fault43;
    wire wr_uart;
    wire wr_spi;
    reg [15:0] next_read;
    reg [15:0] wr_image;

    assign addr_take = hsel_i & htrans_i[`RMIS_HTRANS_NONSEQ_BIT] & hready_i;
    assign addr_idx = haddr_i[`RMIS_IDX_MSB:`RMIS_IDX_LSB];
    // Anything above the eight words is unmapped and reads zero
    assign addr_hit = (haddr_i[31:`RMIS_ADDR_TOP_LSB] == 27'h0000000);
    // Data phase bytes; the upper half of the bus word is never stored
    assign wr_hi = hwdata_i[`RMIS_HI_MSB:`RMIS_HI_LSB];
    assign wr_lo = hwdata_i[`RMIS_LO_MSB:`RMIS_LO_LSB];
    assign wr_timer1 = wr_pend & (wr_idx == `RMIS_IDX_T1CLK);
    assign wr_timer3_timer2 = wr_pend & (wr_idx == `RMIS_IDX_T3T2CLK);
    assign wr_capture1 = wr_pend & (wr_idx == `RMIS_IDX_CAP1);
    assign wr_compare_fault = wr_pend & (wr_idx == `RMIS_IDX_CFLTA);
    assign wr_pwm_fault21 = wr_pend & (wr_idx == `RMIS_IDX_FLT21);
    assign wr_pwm_fault43 = wr_pend & (wr_idx == `RMIS_IDX_FLT43);
    assign wr_uart = wr_pend & (wr_idx == `RMIS_IDX_UART);
    assign wr_spi = wr_pend & (wr_idx == `RMIS_IDX_SPI);

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            wr_pend <= 1'b0;
            wr_idx <= 3'h0;
        end else begin
            wr_pend <= addr_take & hwrite_i & addr_hit;
            wr_idx <= addr_idx;
        end
    end

    // ----------------------------------------
    // Selector fields, one byte each
    // ----------------------------------------
    reg [`RMIS_SEL_W-1:0] timer1_clock_pin_sel;
    reg [`RMIS_SEL_W-1:0] timer2_clock_pin_sel;
    reg [`RMIS_SEL_W-1:0] timer3_clock_pin_sel;
    reg [`RMIS_SEL_W-1:0] capture1_pin_sel;
    reg [`RMIS_SEL_W-1:0] compare_fault_a_pin_sel;
    reg [`RMIS_SEL_W-1:0] pwm_fault1_pin_sel;
    reg [`RMIS_SEL_W-1:0] pwm_fault2_pin_sel;
    reg [`RMIS_SEL_W-1:0] pwm_fault3_pin_sel;
    reg [`RMIS_SEL_W-1:0] pwm_fault4_pin_sel;
    reg [`RMIS_SEL_W-1:0] uart_cts_pin_sel;
    reg [`RMIS_SEL_W-1:0] uart_rx_pin_sel;
    reg [`RMIS_SEL_W-1:0] spi_clock_in_pin_sel;
    reg [`RMIS_SEL_W-1:0] spi_data_in_pin_sel;

    // Low byte has no storage, so its half of a write is dropped
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            timer1_clock_pin_sel <= `RMIS_RESET_SEL;
        end else if (wr_timer1) begin
            timer1_clock_pin_sel <= wr_hi;
        end
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            timer3_clock_pin_sel <= `RMIS_RESET_SEL;
            timer2_clock_pin_sel <= `RMIS_RESET_SEL;
        end else if (wr_timer3_timer2) begin
            timer3_clock_pin_sel <= wr_hi;
            timer2_clock_pin_sel <= wr_lo;
        end
    end

    // Upper byte has no storage
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            capture1_pin_sel <= `RMIS_RESET_SEL;
        end else if (wr_capture1) begin
            capture1_pin_sel <= wr_lo;
        end
    end

    // Upper byte has no storage
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            compare_fault_a_pin_sel <= `RMIS_RESET_SEL;
        end else if (wr_compare_fault) begin
            compare_fault_a_pin_sel <= wr_lo;
        end
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pwm_fault2_pin_sel <= `RMIS_RESET_SEL;
            pwm_fault1_pin_sel <= `RMIS_RESET_SEL;
        end else if (wr_pwm_fault21) begin
            pwm_fault2_pin_sel <= wr_hi;
            pwm_fault1_pin_sel <= wr_lo;
        end
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pwm_fault4_pin_sel <= `RMIS_RESET_SEL;
            pwm_fault3_pin_sel <= `RMIS_RESET_SEL;
        end else if (wr_pwm_fault43) begin
            pwm_fault4_pin_sel <= wr_hi;
            pwm_fault3_pin_sel <= wr_lo;
        end
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            uart_cts_pin_sel <= `RMIS_RESET_SEL;
            uart_rx_pin_sel <= `RMIS_RESET_SEL;
        end else if (wr_uart) begin
            uart_cts_pin_sel <= wr_hi;
            uart_rx_pin_sel <= wr_lo;
        end
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            spi_clock_in_pin_sel <= `RMIS_RESET_SEL;
            spi_data_in_pin_sel <= `RMIS_RESET_SEL;
        end else if (wr_spi) begin
            spi_clock_in_pin_sel <= wr_hi;
            spi_data_in_pin_sel <= wr_lo;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Register images; bytes without a selector read zero
    wire [15:0] timer1_clock_input_select;
    wire [15:0] timer3_timer2_clock_input_select;
    wire [15:0] capture1_input_select;
    wire [15:0] compare_fault_a_input_select;
    wire [15:0] pwm_fault2_fault1_input_select;
    wire [15:0] pwm_fault4_fault3_input_select;
    wire [15:0] uart_cts_rx_input_select;
    wire [15:0] spi_clock_data_input_select;

    assign timer1_clock_input_select = {timer1_clock_pin_sel, `RMIS_SEL_GND};
    assign timer3_timer2_clock_input_select = {timer3_clock_pin_sel, timer2_clock_pin_sel};
    assign capture1_input_select = {`RMIS_SEL_GND, capture1_pin_sel};
    assign compare_fault_a_input_select = {`RMIS_SEL_GND, compare_fault_a_pin_sel};
    assign pwm_fault2_fault1_input_select = {pwm_fault2_pin_sel, pwm_fault1_pin_sel};
    assign pwm_fault4_fault3_input_select = {pwm_fault4_pin_sel, pwm_fault3_pin_sel};
    assign uart_cts_rx_input_select = {uart_cts_pin_sel, uart_rx_pin_sel};
    assign spi_clock_data_input_select = {spi_clock_in_pin_sel, spi_data_in_pin_sel};

    // Word being written, masked the same way as the stored bytes
    always @* begin
        case (wr_idx)
            `RMIS_IDX_T1CLK: wr_image = {wr_hi, `RMIS_SEL_GND};
            `RMIS_IDX_CAP1: wr_image = {`RMIS_SEL_GND, wr_lo};
            `RMIS_IDX_CFLTA: wr_image = {`RMIS_SEL_GND, wr_lo};
            default: wr_image = {wr_hi, wr_lo};
        endcase
    end

    always @* begin
        case (addr_idx)
            `RMIS_IDX_T1CLK: next_read = timer1_clock_input_select;
            `RMIS_IDX_T3T2CLK: next_read = timer3_timer2_clock_input_select;
            `RMIS_IDX_CAP1: next_read = capture1_input_select;
            `RMIS_IDX_CFLTA: next_read = compare_fault_a_input_select;
            `RMIS_IDX_FLT21: next_read = pwm_fault2_fault1_input_select;
            `RMIS_IDX_FLT43: next_read = pwm_fault4_fault3_input_select;
            `RMIS_IDX_UART: next_read = uart_cts_rx_input_select;
            default: next_read = spi_clock_data_input_select;
        endcase
        if (!addr_hit) begin
            next_read = `RMIS_ZERO_HALF;
        end else if (wr_pend && (wr_idx == addr_idx)) begin
            // A read right behind a write to the same word sees the new value
            next_read = wr_image;
        end
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= `RMIS_HRESP_OKAY;
            hrdata_o <= `RMIS_ZERO_WORD;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= `RMIS_HRESP_OKAY;
            if (addr_take && !hwrite_i) begin
                hrdata_o <= {`RMIS_ZERO_HALF, next_read};
            end
        end
    end

    // ----------------------------------------
    // Peripheral input map
    // ----------------------------------------
    // Pin direction is left to software; a remapped input never drives it
    // Each route is registered inside the mux, so outputs leave a flop
    rmis_pin_mux timer1_clock_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(timer1_clock_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(timer1_clock_o)
    );
    rmis_pin_mux timer2_clock_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(timer2_clock_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(timer2_clock_o)
    );
    rmis_pin_mux timer3_clock_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(timer3_clock_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(timer3_clock_o)
    );
    rmis_pin_mux capture1_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(capture1_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(capture1_o)
    );
    rmis_pin_mux compare_fault_a_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(compare_fault_a_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(compare_fault_a_o)
    );
    rmis_pin_mux pwm_fault1_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(pwm_fault1_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(pwm_fault1_o)
    );
    rmis_pin_mux pwm_fault2_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(pwm_fault2_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(pwm_fault2_o)
    );
    rmis_pin_mux pwm_fault3_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(pwm_fault3_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(pwm_fault3_o)
    );
    rmis_pin_mux pwm_fault4_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(pwm_fault4_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(pwm_fault4_o)
    );
    rmis_pin_mux uart_rx_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(uart_rx_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(uart_rx_o)
    );
    rmis_pin_mux uart_cts_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(uart_cts_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(uart_cts_o)
    );
    rmis_pin_mux spi_data_in_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(spi_data_in_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(spi_data_in_o)
    );
    rmis_pin_mux spi_clock_in_mux (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sel_i(spi_clock_in_pin_sel),
        .pins_i(remappable_pin_i),
        .route_o(spi_clock_in_o)
    );
endmodule

// ==== rmis_props.sv ====
// Port checks for the remappable input select block.
// Assumes binding to rmis_top: one clock, active-low synchronous reset.
module rmis_props (
    input wire mclk_i, input wire reset_n_i,
    input wire hsel_i, input wire [31:0] haddr_i, input wire [1:0] htrans_i,
    input wire hwrite_i, input wire hready_i,
    input wire hreadyout_o, input wire hresp_o, input wire [31:0] hrdata_o,
    input wire [181:0] remappable_pin_i,
    input wire timer1_clock_o, input wire capture1_o, input wire spi_clock_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    wire rd = hsel_i & htrans_i[1] & hready_i & !hwrite_i;
    wire [2:0] outs = {timer1_clock_o, capture1_o, spi_clock_in_o};
    property p_rst; $rose(reset_n_i) |-> outs == 3'h0 && hrdata_o == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("not clear after reset");
    property p_gnd; $past(remappable_pin_i) == 182'h0 |-> outs == 3'h0; endproperty
    a_gnd: assert property (p_gnd) else $error("output high with pins low");
    property p_okay; hreadyout_o && !hresp_o; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not ready okay");
    property p_hi; hrdata_o[31:16] == 16'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read half not zero");
    property p_unm; rd && haddr_i[31:5] != 27'h0 |=> hrdata_o == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_hold; !rd |=> $stable(hrdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_t1lo; rd && haddr_i == 32'h0 |=> hrdata_o[7:0] == 8'h0; endproperty
    a_t1lo: assert property (p_t1lo) else $error("timer1 low byte set");
    property p_caphi; rd && haddr_i == 32'h8 |=> hrdata_o[15:8] == 8'h0; endproperty
    a_caphi: assert property (p_caphi) else $error("capture upper byte set");
    property p_cfahi; rd && haddr_i == 32'hc |=> hrdata_o[15:8] == 8'h0; endproperty
    a_cfahi: assert property (p_cfahi) else $error("compare upper byte set");
    c_rd: cover property (rd);
    c_t1: cover property ($rose(timer1_clock_o));
    c_spi: cover property ($rose(spi_clock_in_o));
endmodule

// ==== rmis_pin_drv.sv ====
// Far side: one pin at a chosen level, all other pins at the opposite.
// Assumes its controls change right after a rising edge.
module rmis_pin_drv (
    input wire mclk_i,
    input wire [7:0] pin_i,
    input wire lvl_i,
    output logic [181:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins stay inputs; direction is set by software, never by the mux
    always @(posedge mclk_i) pins_o <= lvl_i ? 182'h1 << pin_i : ~(182'h1 << pin_i);
endmodule

// ==== remappable_input_select_tb_top.sv ====
// Bench for the remappable input select block over AHB-Lite.
// Assumes rmis_top, rmis_pin_drv and rmis_props are compiled first.
module remappable_input_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, reset_n_i = 0, hsel = 0, hwrite = 0, lvl = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [7:0] pin = 8'h0;
    wire [181:0] pins;
    wire hrdy, hresp;
    wire [31:0] hrdata;
    wire [12:0] outs;
    int num_errors = 0, checks_done = 0;
    logic [15:0] mask [9] = '{16'hff00, 16'hffff, 16'h00ff, 16'h00ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0};
    int slot [13] = '{1, 2, 3, 4, 6, 8, 9, 10, 11, 12, 13, 14, 15};
    logic [7:0] code [6] = '{8'h01, 8'hb4, 8'hb5, 8'h00, 8'hb6, 8'hff};
    rmis_top rmis_top_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .remappable_pin_i(pins),
        .timer1_clock_o(outs[12]), .timer2_clock_o(outs[11]), .timer3_clock_o(outs[10]),
        .capture1_o(outs[9]), .compare_fault_a_o(outs[8]), .pwm_fault1_o(outs[7]),
        .pwm_fault2_o(outs[6]), .pwm_fault3_o(outs[5]), .pwm_fault4_o(outs[4]), .uart_rx_o(outs[3]),
        .uart_cts_o(outs[2]), .spi_data_in_o(outs[1]), .spi_clock_in_o(outs[0]));
    rmis_pin_drv rmis_pin_drv_inst (.mclk_i(mclk_i), .pin_i(pin), .lvl_i(lvl), .pins_o(pins));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        @(posedge mclk_i);
        while (hrdy !== 1'b1) @(posedge mclk_i);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge mclk_i);
        while (hrdy !== 1'b1) @(posedge mclk_i);
        q = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial forever #2.5 mclk_i = ~mclk_i;
    initial begin
        #20000;
        num_errors++;
        conclude();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        chk("outs after reset", 32'h0, {19'h0, outs});
        for (int i = 0; i < 9; i++) begin
            xfer(1'b0, 32'(i * 4), 32'h0);
            chk("reset value", 32'h0, q);
            xfer(1'b1, 32'(i * 4), 32'hffffffff);
            xfer(1'b0, 32'(i * 4), 32'h0);
            chk("readback", {16'h0, mask[i]}, q);
        end
        // Distinct pin per slot, so a swapped byte shows up
        for (int r = 0; r < 8; r++) xfer(1'b1, 32'(r * 4), {16'h0, 8'(2 * r + 41), 8'(2 * r + 40)});
        lvl <= 1'b1;
        for (int j = 0; j < 13; j++) begin
            pin <= 8'(40 + slot[j]);
            repeat (3) @(posedge mclk_i);
            chk("routed input", 32'h1000 >> j, {19'h0, outs});
        end
        for (int c = 0; c < 6; c++) begin
            for (int r = 0; r < 8; r++) xfer(1'b1, 32'(r * 4), {16'h0, code[c], code[c]});
            pin <= code[c];
            for (int l = 0; l < 2; l++) begin
                lvl <= l[0];
                repeat (3) @(posedge mclk_i);
                chk("shared pin", (l == 1 && code[c] != 8'h0 && code[c] <= 8'hb5) ? 32'h1fff : 32'h0, {19'h0, outs});
            end
        end
        reset_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        xfer(1'b0, 32'h4, 32'h0);
        chk("value after second reset", 32'h0, q);
        conclude();
    end
endmodule
bind rmis_top rmis_props rmis_props_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .remappable_pin_i(remappable_pin_i),
    .timer1_clock_o(timer1_clock_o), .capture1_o(capture1_o), .spi_clock_in_o(spi_clock_in_o));
